// File: common/fpebc_mem_if.sv
// Port bundle between the sequencer and one of its memories.
`default_nettype none
interface fpebc_mem_if #(parameter int AW = 13, parameter int DW = 8) ();
   logic en; // Access enable.
   logic we; // Write when high, read when low.
   logic [AW-1:0] addr; // Word address.
   logic [DW-1:0] wdata; // Write data.
   logic [DW-1:0] rdata; // Registered read data.
   modport ctl (output en, output we, output addr, output wdata, input rdata);
   modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// File: common/fpebc_pkg.sv
// Constants, register map and state type of the flash program, erase and boot controller.
`default_nettype none
package fpebc_pkg;
   // Array geometry.
   localparam int unsigned SECTOR_BYTES = 1024;
   localparam int unsigned PAGE_BYTES = 64;
   localparam int unsigned MAX_SECTORS = 8;
   localparam int unsigned AW = 13;
   localparam int unsigned PW = 6;
   localparam int unsigned LOADER_BYTES = 512;
   localparam logic [7:0] ERASED = 8'hff;
   // Boot elements and their factory values.
   localparam logic [7:0] BOOT_VEC_SMALL = 8'h0f;
   localparam logic [7:0] BOOT_VEC_LARGE = 8'h1f;
   localparam logic [7:0] BOOT_STAT_DEF = 8'h00;
   localparam logic [7:0] BOOT_LOW = 8'h00;
   localparam logic [15:0] USER_START = 16'h0000;
   // Identity value; the value is arbitrary.
   localparam logic [7:0] DEV_ID_DEF = 8'h5a;
   // Operation time and its cycle count at the 50 ns clock.
   localparam int unsigned OP_TIME_US = 2000;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned OP_CYC = (OP_TIME_US * 1000) / CLK_PERIOD_NS;
   // Register offsets.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_DATA = 4'h1;
   localparam logic [3:0] REG_ADDR_LO = 4'h2;
   localparam logic [3:0] REG_ADDR_HI = 4'h3;
   localparam logic [3:0] REG_SECURE = 4'h4;
   localparam logic [3:0] REG_CRC0 = 4'h5;
   localparam logic [3:0] REG_CRC1 = 4'h6;
   localparam logic [3:0] REG_CRC2 = 4'h7;
   localparam logic [3:0] REG_CRC3 = 4'h8;
   localparam logic [3:0] REG_BOOT_VEC = 4'h9;
   localparam logic [3:0] REG_BOOT_STAT = 4'ha;
   localparam logic [3:0] REG_DEV_ID = 4'hb;
   // Control register fields: command in bits 3:0, flag clear in bit 7.
   localparam int unsigned CTRL_CLR_BIT = 7;
   // Command codes.
   localparam logic [3:0] CMD_NONE = 4'h0;
   localparam logic [3:0] CMD_BYTE_ERASE = 4'h1;
   localparam logic [3:0] CMD_PAGE_ERASE = 4'h2;
   localparam logic [3:0] CMD_SECTOR_ERASE = 4'h3;
   localparam logic [3:0] CMD_CHIP_ERASE = 4'h4;
   localparam logic [3:0] CMD_PROGRAM = 4'h5;
   localparam logic [3:0] CMD_CRC_SECTOR = 4'h6;
   localparam logic [3:0] CMD_CRC_ALL = 4'h7;
   // Reflected CRC-32 polynomial and start value.
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   // Sequencer states.
   typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_CRC, ST_HOLD} fpebc_state_e;
endpackage
`default_nettype wire

// File: core/fpebc_mem.sv
// Single-port memory with registered read data, used for the array and the page buffer.
`default_nettype none
module fpebc_mem #(
   parameter int AW = 13,
   parameter int DW = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   fpebc_mem_if.mem port
);
   logic [DW-1:0] cells [0:(1<<AW)-1]; // Storage cells.
   logic [DW-1:0] rdata_ff; // Read data register.
   logic [DW-1:0] nxt_rdata; // Next read data.

   // Writes go into the cells; storage has no reset, as a flash array keeps nothing defined.
   always_ff @(posedge sys_clk) begin
      if (port.en && port.we) begin
         cells[port.addr] <= port.wdata;
      end
   end

   // A read returns the addressed word one cycle later and holds it otherwise.
   always_comb begin
      nxt_rdata = rdata_ff;
      if (port.en && !port.we) begin
         nxt_rdata = cells[port.addr];
      end
   end

   // Read data register.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign port.rdata = rdata_ff;
endmodule
`default_nettype wire

// File: core/fpebc_top.sv
// Flash sequencer: erase, page programming, security, CRC check and boot address choice.
`default_nettype none
module fpebc_top
   import fpebc_pkg::*;
#(
   parameter int unsigned NUM_SECTORS = 8,
   parameter int unsigned OP_CYC_P = OP_CYC,
   parameter logic [7:0] BOOT_VEC_DEF = (NUM_SECTORS == 4) ? BOOT_VEC_SMALL : BOOT_VEC_LARGE
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_ff,
   input wire logic code_rd,
   input wire logic [12:0] code_addr,
   output logic [7:0] code_rdata_ff,
   output logic code_rvalid_ff,
   output logic code_denied_ff,
   input wire logic low_supply_pin,
   input wire logic isp_force_pin,
   output logic [15:0] boot_addr_ff,
   output logic boot_ready_ff,
   output logic flash_busy_ff
);
   localparam logic [12:0] CHIP_END = 13'(NUM_SECTORS * SECTOR_BYTES - 1);

   // One CRC-32 step over a byte, least significant bit first.
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   fpebc_mem_if #(.AW(AW), .DW(8)) arr_if (); // Code array port.
   fpebc_mem_if #(.AW(PW), .DW(8)) buf_if (); // Page buffer port.

   // The code array and the 64-byte page buffer.
   fpebc_mem #(.AW(AW), .DW(8)) u_array (.sys_clk(sys_clk), .rst_n(rst_n), .port(arr_if.mem));
   fpebc_mem #(.AW(PW), .DW(8)) u_page_buf (.sys_clk(sys_clk), .rst_n(rst_n), .port(buf_if.mem));

   logic low_s1_ff, low_s2_ff, isp_s1_ff, isp_s2_ff; // Pin synchronisers.
   fpebc_state_e state_ff, nxt_state; // Sequencer state.
   logic [3:0] op_ff, nxt_op; // Command being carried out.
   logic [12:0] addr_ff, nxt_addr; // Software address.
   logic [12:0] walk_ff, nxt_walk; // Address being visited.
   logic [12:0] end_ff, nxt_end; // Last address to visit.
   logic run_ff, nxt_run; // Walk still issuing accesses.
   logic pend_ff, nxt_pend; // Read data due this cycle.
   logic [12:0] pidx_ff, nxt_pidx; // Address of the pending read.
   logic [15:0] timer_ff, nxt_timer; // Operation time counter.
   logic [PAGE_BYTES-1:0] mask_ff, nxt_mask; // Loaded page buffer bytes.
   logic [MAX_SECTORS-1:0] sec_ff, nxt_sec; // Per-sector security.
   logic [31:0] crc_ff, nxt_crc; // CRC result.
   logic [7:0] vec_ff, nxt_vec; // Boot vector.
   logic [7:0] stat_ff, nxt_stat; // Boot status.
   logic lowref_ff, nxt_lowref; // Operation refused or stopped by low supply.
   logic done_ff, nxt_done; // Operation finished.
   logic crd_ff, nxt_crd, cden_ff, nxt_cden; // Code read in flight and its refusal.
   logic [1:0] bcnt_ff, nxt_bcnt; // Boot decision delay.
   logic [7:0] nxt_rdata, nxt_code_data;
   logic nxt_code_valid, nxt_code_denied, nxt_boot_ready, nxt_busy;
   logic [15:0] nxt_boot_addr;
   logic start; // A command write this cycle.

   // Two flip-flops bring the supply detector and the programming strap into the clock domain.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_s1_ff <= 1'b0;
         low_s2_ff <= 1'b0;
         isp_s1_ff <= 1'b0;
         isp_s2_ff <= 1'b0;
      end else begin
         low_s1_ff <= low_supply_pin;
         low_s2_ff <= low_s1_ff;
         isp_s1_ff <= isp_force_pin;
         isp_s2_ff <= isp_s1_ff;
      end
   end

   assign start = reg_wr && (reg_addr == REG_CTRL) && (reg_wdata[3:0] != CMD_NONE);

   // Next values of the sequencer, the registers and the memory ports.
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_addr = addr_ff;
      nxt_walk = walk_ff;
      nxt_end = end_ff;
      nxt_run = run_ff;
      nxt_pend = 1'b0;
      nxt_pidx = walk_ff;
      nxt_timer = timer_ff;
      nxt_mask = mask_ff;
      nxt_sec = sec_ff;
      nxt_crc = crc_ff;
      nxt_vec = vec_ff;
      nxt_stat = stat_ff;
      nxt_lowref = lowref_ff;
      nxt_done = done_ff;
      nxt_crd = 1'b0;
      nxt_cden = 1'b0;
      nxt_bcnt = bcnt_ff;
      nxt_boot_ready = boot_ready_ff;
      nxt_boot_addr = boot_addr_ff;
      arr_if.en = 1'b0;
      arr_if.we = 1'b0;
      arr_if.addr = walk_ff;
      arr_if.wdata = ERASED;
      buf_if.en = 1'b0;
      buf_if.we = 1'b0;
      buf_if.addr = walk_ff[5:0];
      buf_if.wdata = reg_wdata;
      // Register reads answer in the next cycle only; unmapped offsets read zero.
      nxt_rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: nxt_rdata = {4'h0, done_ff, low_s2_ff, lowref_ff, state_ff != ST_IDLE};
            REG_ADDR_LO: nxt_rdata = addr_ff[7:0];
            REG_ADDR_HI: nxt_rdata = {3'h0, addr_ff[12:8]};
            REG_SECURE: nxt_rdata = sec_ff;
            REG_CRC0: nxt_rdata = crc_ff[7:0];
            REG_CRC1: nxt_rdata = crc_ff[15:8];
            REG_CRC2: nxt_rdata = crc_ff[23:16];
            REG_CRC3: nxt_rdata = crc_ff[31:24];
            REG_BOOT_VEC: nxt_rdata = vec_ff;
            REG_BOOT_STAT: nxt_rdata = stat_ff;
            REG_DEV_ID: nxt_rdata = DEV_ID_DEF;
            default: nxt_rdata = 8'h00;
         endcase
      end
      // Flags are cleared by software first so that a finishing event set below wins.
      if (reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_CLR_BIT]) begin
         nxt_lowref = 1'b0;
         nxt_done = 1'b0;
      end
      // Code reads return two cycles later; a secured sector or a busy array yields a refusal.
      nxt_code_valid = crd_ff;
      nxt_code_denied = cden_ff;
      nxt_code_data = (crd_ff && !cden_ff) ? arr_if.rdata : 8'h00;
      if (code_rd) begin
         nxt_crd = 1'b1;
         nxt_cden = sec_ff[code_addr[12:10]] || (state_ff != ST_IDLE);
         if (!nxt_cden) begin
            arr_if.en = 1'b1;
            arr_if.addr = code_addr;
         end
      end
      // The boot choice is made once the strap has crossed both synchroniser stages.
      if (!boot_ready_ff) begin
         nxt_bcnt = bcnt_ff + 2'd1;
         if (bcnt_ff == 2'd2) begin
            nxt_boot_ready = 1'b1;
            nxt_boot_addr = USER_START;
            if ((stat_ff != 8'h00) || isp_s2_ff) begin
               nxt_boot_addr = {vec_ff, BOOT_LOW};
            end
         end
      end
      // The timer runs throughout every operation.
      if (state_ff != ST_IDLE) begin
         nxt_timer = timer_ff + 16'd1;
      end
      unique case (state_ff)
         ST_IDLE: begin
            // Address, data, security and boot registers are written only while idle.
            if (reg_wr) begin
               unique case (reg_addr)
                  REG_ADDR_LO: nxt_addr = {addr_ff[12:8], reg_wdata};
                  REG_ADDR_HI: nxt_addr = {reg_wdata[4:0], addr_ff[7:0]};
                  REG_SECURE: nxt_sec = sec_ff | reg_wdata;
                  REG_BOOT_VEC: nxt_vec = reg_wdata;
                  REG_BOOT_STAT: nxt_stat = reg_wdata;
                  REG_DATA: begin
                     // Load one byte into the page buffer and step the address.
                     buf_if.en = 1'b1;
                     buf_if.we = 1'b1;
                     buf_if.addr = addr_ff[5:0];
                     nxt_mask[addr_ff[5:0]] = 1'b1;
                     nxt_addr = addr_ff + 13'd1;
                  end
                  default: nxt_addr = addr_ff;
               endcase
            end
            if (start && low_s2_ff && (reg_wdata[3:0] < CMD_CRC_SECTOR)) begin
               nxt_lowref = 1'b1;
            end else if (start) begin
               nxt_op = reg_wdata[3:0];
               nxt_timer = 16'd0;
               nxt_run = 1'b1;
               nxt_done = 1'b0;
               nxt_walk = {addr_ff[12:10], 10'h000};
               nxt_end = {addr_ff[12:10], 10'h3ff};
               nxt_state = ST_ERASE;
               unique case (reg_wdata[3:0])
                  CMD_BYTE_ERASE: begin
                     nxt_walk = addr_ff;
                     nxt_end = addr_ff;
                  end
                  CMD_PAGE_ERASE: begin
                     nxt_walk = {addr_ff[12:6], 6'h00};
                     nxt_end = {addr_ff[12:6], 6'h3f};
                  end
                  CMD_SECTOR_ERASE: nxt_state = ST_ERASE;
                  CMD_CHIP_ERASE: begin
                     nxt_walk = 13'h0000;
                     nxt_end = CHIP_END;
                  end
                  CMD_PROGRAM: begin
                     nxt_walk = {addr_ff[12:6], 6'h00};
                     nxt_end = {addr_ff[12:6], 6'h3f};
                     nxt_state = ST_PROG;
                  end
                  CMD_CRC_SECTOR: begin
                     nxt_crc = CRC_INIT;
                     nxt_state = ST_CRC;
                  end
                  CMD_CRC_ALL: begin
                     nxt_walk = 13'h0000;
                     nxt_end = CHIP_END;
                     nxt_crc = CRC_INIT;
                     nxt_state = ST_CRC;
                  end
                  default: begin
                     nxt_run = 1'b0;
                     nxt_state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_ERASE: begin
            // One erased byte per cycle over the chosen range.
            arr_if.en = 1'b1;
            arr_if.we = 1'b1;
            nxt_walk = walk_ff + 13'd1;
            if (walk_ff == end_ff) begin
               nxt_run = 1'b0;
               nxt_state = ST_HOLD;
            end
         end
         ST_PROG: begin
            // Buffer bytes are read in order and the loaded ones written a cycle later.
            if (run_ff) begin
               buf_if.en = 1'b1;
               nxt_pend = 1'b1;
               nxt_walk = walk_ff + 13'd1;
               nxt_run = (walk_ff != end_ff);
            end
            if (pend_ff && mask_ff[pidx_ff[5:0]]) begin
               arr_if.en = 1'b1;
               arr_if.we = 1'b1;
               arr_if.addr = pidx_ff;
               arr_if.wdata = buf_if.rdata;
            end
            if (!run_ff && !pend_ff) begin
               nxt_mask = '0;
               nxt_state = ST_HOLD;
            end
         end
         ST_CRC: begin
            // Array bytes are read in order and folded into the CRC.
            if (run_ff) begin
               arr_if.en = 1'b1;
               nxt_pend = 1'b1;
               nxt_walk = walk_ff + 13'd1;
               nxt_run = (walk_ff != end_ff);
            end
            if (pend_ff) begin
               nxt_crc = crc_step(crc_ff, arr_if.rdata);
            end
            if (!run_ff && !pend_ff) begin
               nxt_done = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         ST_HOLD: begin
            // The operation ends when its fixed time has run out.
            if (timer_ff >= 16'(OP_CYC_P - 1)) begin
               nxt_done = 1'b1;
               nxt_state = ST_IDLE;
               if (op_ff == CMD_CHIP_ERASE) begin
                  nxt_sec = '0;
               end
            end
         end
      endcase
      // A low supply stops any running erase or program at once.
      if (low_s2_ff && (state_ff != ST_IDLE) && (state_ff != ST_CRC)) begin
         nxt_state = ST_IDLE;
         nxt_run = 1'b0;
         nxt_pend = 1'b0;
         nxt_done = 1'b0;
         nxt_lowref = 1'b1;
      end
      nxt_busy = (nxt_state != ST_IDLE);
   end

   // State and register update; boot elements reset to their factory values.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         op_ff <= CMD_NONE;
         addr_ff <= '0;
         walk_ff <= '0;
         end_ff <= '0;
         run_ff <= 1'b0;
         pend_ff <= 1'b0;
         pidx_ff <= '0;
         timer_ff <= '0;
         mask_ff <= '0;
         sec_ff <= '0;
         crc_ff <= CRC_INIT;
         vec_ff <= BOOT_VEC_DEF;
         stat_ff <= BOOT_STAT_DEF;
         lowref_ff <= 1'b0;
         done_ff <= 1'b0;
         crd_ff <= 1'b0;
         cden_ff <= 1'b0;
         bcnt_ff <= 2'd0;
         reg_rdata_ff <= 8'h00;
         code_rdata_ff <= 8'h00;
         code_rvalid_ff <= 1'b0;
         code_denied_ff <= 1'b0;
         boot_addr_ff <= USER_START;
         boot_ready_ff <= 1'b0;
         flash_busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         addr_ff <= nxt_addr;
         walk_ff <= nxt_walk;
         end_ff <= nxt_end;
         run_ff <= nxt_run;
         pend_ff <= nxt_pend;
         pidx_ff <= nxt_pidx;
         timer_ff <= nxt_timer;
         mask_ff <= nxt_mask;
         sec_ff <= nxt_sec;
         crc_ff <= nxt_crc;
         vec_ff <= nxt_vec;
         stat_ff <= nxt_stat;
         lowref_ff <= nxt_lowref;
         done_ff <= nxt_done;
         crd_ff <= nxt_crd;
         cden_ff <= nxt_cden;
         bcnt_ff <= nxt_bcnt;
         reg_rdata_ff <= nxt_rdata;
         code_rdata_ff <= nxt_code_data;
         code_rvalid_ff <= nxt_code_valid;
         code_denied_ff <= nxt_code_denied;
         boot_addr_ff <= nxt_boot_addr;
         boot_ready_ff <= nxt_boot_ready;
         flash_busy_ff <= nxt_busy;
      end
   end

   // Checks below watch the sequencer on the system clock.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   busy_ignore_a: assert property (state_ff != ST_IDLE && start |=> op_ff == $past(op_ff))
      else $error("command accepted while busy");
   low_refuse_a: assert property (state_ff == ST_IDLE && start && low_s2_ff && reg_wdata[3:0] < CMD_CRC_SECTOR
      |=> state_ff == ST_IDLE && lowref_ff)
      else $error("operation started under low supply");
   low_abort_a: assert property (low_s2_ff && (state_ff == ST_ERASE || state_ff == ST_PROG || state_ff == ST_HOLD)
      |=> state_ff == ST_IDLE)
      else $error("operation continued under low supply");
   op_time_a: assert property (state_ff != ST_IDLE |-> timer_ff < 16'(OP_CYC_P))
      else $error("operation exceeded its time");
   secure_read_a: assert property (code_rd && sec_ff[code_addr[12:10]]
      |=> ##1 code_rvalid_ff && code_denied_ff && code_rdata_ff == 8'h00)
      else $error("secured byte was readable");
   open_read_a: assert property (code_rd && !sec_ff[code_addr[12:10]] && state_ff == ST_IDLE
      |=> ##1 code_rvalid_ff && !code_denied_ff)
      else $error("open byte was refused");
   boot_user_a: assert property ($rose(boot_ready_ff) && $past(stat_ff) == 8'h00 && !$past(isp_s2_ff)
      |-> boot_addr_ff == USER_START)
      else $error("boot did not start at zero");
   boot_vector_a: assert property ($rose(boot_ready_ff) && ($past(stat_ff) != 8'h00 || $past(isp_s2_ff))
      |-> boot_addr_ff == {$past(vec_ff), BOOT_LOW})
      else $error("boot did not use the vector");
   erase_walk_a: assert property (state_ff == ST_ERASE |-> arr_if.we && arr_if.wdata == ERASED
      && walk_ff <= end_ff)
      else $error("erase wrote outside its range");
   crc_end_a: assert property (state_ff == ST_CRC && !run_ff && !pend_ff |=> state_ff == ST_IDLE && done_ff)
      else $error("crc did not finish");
endmodule
`default_nettype wire

// File: verif/fpebc_core_model.sv
// Processor core model that drives the flash controller's register port.
`default_nettype none
module fpebc_core_model
   import fpebc_pkg::*;
(
   input wire logic sys_clk,
   output var logic [3:0] reg_addr,
   output var logic [7:0] reg_wdata,
   output var logic reg_wr,
   output var logic reg_rd,
   input wire logic [7:0] reg_rdata_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   // The bus is idle at time zero.
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One-cycle write; released data is inverted so that stale values never look valid.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // One-cycle read; data is taken in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_ff;
   endtask
   // After new code the programmer returns the boot choice to the user application.
   task automatic clear_boot();
      wr(REG_BOOT_STAT, 8'h00);
   endtask
   // Common entry of an in-application call: the task only writes the command into the control register.
   task automatic call_entry(input logic [3:0] cmd);
      wr(REG_CTRL, {4'h0, cmd});
   endtask
endmodule
`default_nettype wire

// File: verif/tb_flash_program_erase_boot_control.sv
// Self-checking bench for the flash program, erase and boot controller.
`default_nettype none
module tb_flash_program_erase_boot_control
   import fpebc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned OPC = 1100; // Shortened operation time, still longer than a sector walk.
   logic sys_clk = 1'b0, rst_n = 1'b0, code_rd = 1'b0, low_supply_pin = 1'b0, isp_force_pin = 1'b0;
   logic [12:0] code_addr = 13'h0000;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata_ff, code_rdata_ff, d;
   logic reg_wr, reg_rd, code_rvalid_ff, code_denied_ff, boot_ready_ff, flash_busy_ff;
   logic [15:0] boot_addr_ff;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   always #25 sys_clk = ~sys_clk;
   fpebc_core_model core (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));
   fpebc_top #(.NUM_SECTORS(8), .OP_CYC_P(OPC)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .code_rd(code_rd),
      .code_addr(code_addr), .code_rdata_ff(code_rdata_ff), .code_rvalid_ff(code_rvalid_ff),
      .code_denied_ff(code_denied_ff), .low_supply_pin(low_supply_pin), .isp_force_pin(isp_force_pin),
      .boot_addr_ff(boot_addr_ff), .boot_ready_ff(boot_ready_ff), .flash_busy_ff(flash_busy_ff));
   // Compares a seen value with the expected one.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("comparisons=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         final_report();
      end
   end
   // Resets with the given strap level and waits for the boot address.
   task automatic do_reset(input logic force_isp);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      isp_force_pin <= force_isp;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8 && !boot_ready_ff; i++) @(posedge sys_clk);
      #1 chk(boot_ready_ff, 1'b1);
   endtask
   // Reads one code byte and returns its data and refusal flag.
   task automatic cread(input logic [12:0] a, output logic [7:0] dat, output logic den);
      @(posedge sys_clk);
      code_rd <= 1'b1;
      code_addr <= a;
      @(posedge sys_clk);
      code_rd <= 1'b0;
      code_addr <= ~a;
      @(posedge sys_clk);
      #1 chk(code_rvalid_ff, 1'b1);
      dat = code_rdata_ff;
      den = code_denied_ff;
   endtask
   // Points the address registers at a byte.
   task automatic set_addr(input logic [12:0] a);
      core.wr(REG_ADDR_LO, a[7:0]);
      core.wr(REG_ADDR_HI, {3'h0, a[12:8]});
   endtask
   // Starts a command and follows it to its end.
   task automatic op(input logic [3:0] cmd);
      int n;
      core.call_entry(cmd);
      // A second command while busy must be ignored; an accepted chip erase would wipe the checked bytes.
      core.wr(REG_CTRL, {4'h0, CMD_CHIP_ERASE});
      core.rd(REG_CTRL, d);
      chk(d[0], 1'b1);
      n = 4;
      while (flash_busy_ff === 1'b1 && n < OPC + 20) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk(n <= OPC, 1'b1);
      core.rd(REG_CTRL, d);
      chk({d[3], d[0]}, 2'h2);
      core.wr(REG_CTRL, 8'h80);
   endtask
   // Boot address with and without the forced loader strap.
   task automatic t_boot();
      do_reset(1'b1);
      chk(boot_addr_ff, {BOOT_VEC_LARGE, BOOT_LOW});
      core.clear_boot();
      do_reset(1'b0);
      chk(boot_addr_ff, USER_START);
      $display("boot test done");
   endtask
   // Page program, then byte and page erase.
   task automatic t_prog();
      logic den;
      set_addr(13'h0040);
      op(CMD_SECTOR_ERASE);
      for (int i = 0; i < 3; i++) core.wr(REG_DATA, 8'ha0 + 8'(i));
      set_addr(13'h0040);
      op(CMD_PROGRAM);
      for (int i = 0; i < 3; i++) begin
         cread(13'h0040 + 13'(i), d, den);
         chk(d, 8'ha0 + 8'(i));
      end
      cread(13'h0043, d, den);
      chk(d, ERASED);
      set_addr(13'h0041);
      op(CMD_BYTE_ERASE);
      cread(13'h0041, d, den);
      chk(d, ERASED);
      cread(13'h0040, d, den);
      chk(d, 8'ha0);
      op(CMD_PAGE_ERASE);
      cread(13'h0042, d, den);
      chk(d, ERASED);
      $display("program test done");
   endtask
   // Per-sector read security and low-supply refusal.
   task automatic t_sec_low();
      logic den;
      core.wr(REG_SECURE, 8'h02);
      cread(13'h0400, d, den);
      chk({den, d}, 9'h100);
      cread(13'h0040, d, den);
      chk({den, d}, {1'b0, ERASED});
      // A low supply during a running erase stops it.
      core.call_entry(CMD_BYTE_ERASE);
      low_supply_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 chk(flash_busy_ff, 1'b0);
      core.rd(REG_CTRL, d);
      chk(d[2:1], 2'h3);
      // With the flag cleared, a new erase under low supply is refused and sets it again.
      core.wr(REG_CTRL, 8'h80);
      core.wr(REG_CTRL, {4'h0, CMD_BYTE_ERASE});
      repeat (2) @(posedge sys_clk);
      #1 chk(flash_busy_ff, 1'b0);
      core.rd(REG_CTRL, d);
      chk(d[2:0], 3'h6);
      $display("security and supply test done");
   endtask
   // Reference CRC-32, one bit at a time, least significant bit first, no final inversion.
   function automatic logic [31:0] ref_crc(input logic [31:0] c, input logic [7:0] b);
      logic fb;
      for (int k = 0; k < 8; k++) begin
         fb = c[0] ^ b[k];
         c = (c >> 1) ^ (fb ? CRC_POLY : 32'h00000000);
      end
      return c;
   endfunction
   // Sector CRC over sector 0, which the program test leaves fully erased.
   task automatic t_crc();
      logic [31:0] c, e;
      e = CRC_INIT;
      for (int i = 0; i < 1024; i++) e = ref_crc(e, ERASED);
      op(CMD_CRC_SECTOR);
      for (int i = 0; i < 4; i++) begin
         core.rd(REG_CRC0 + 4'(i), d);
         c[8*i +: 8] = d;
      end
      chk(c[15:0], e[15:0]);
      chk(c[31:16], e[31:16]);
      $display("crc test done");
   endtask
   initial begin
      t_boot();
      t_prog();
      t_crc();
      t_sec_low();
      final_report();
   end
endmodule
`default_nettype wire
